// *** hw/sap_device.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "sap_regs.svh"
// Operation
// - Host never asserts select and memory request together
// - Two clocks between select and request
// - Select and request sampled through synchroniser; select is sampled raw in SAP_ACK and SAP_DONE
// - Acknowledge 1 clock idle, 5 as master
// - Each master wait state adds one clock
// - Acknowledge within bounded delay of request
// - Memory acknowledge holds while request held
// - Register acknowledge needs select and strobe
// - Acknowledge released between register accesses
// - Ready at least 2.5 clocks after acknowledge
// - Strobe or select release ends access
// - Strobe active no later than select
// - Strobe released within one clock of select
// - Select idle one clock between accesses
module sap_device
   import sap_pkg::*;
#(
   parameter int AW = 6,
   parameter int DW = 16
) (
   input wire logic core_clk,
   input wire logic rstn,
   sap_if.device bus,
   input wire logic bus_master,
   input wire logic master_wait,
   input wire logic [DW-1:0] reg_rdata,
   output logic [AW-1:0] reg_addr,
   output logic reg_write,
   output logic [DW-1:0] reg_wdata,
   output logic reg_read,
   output logic mem_granted
);
   sap_state_type state_q;
   logic cs_s1_q, cs_s2_q, mr_s1_q, mr_s2_q;
   logic [2:0] dly_q;
   logic [1:0] rdy_cnt_q;
   logic is_mem_q, wr_q, ack_n_q, rdy_n_q, oe_q, mem_granted_q;
   logic [DW-1:0] rdata_q;
   logic strobe_act;
   logic reg_live;
   logic rdy_fire;
   logic [AW-1:0] addr_q;
   logic [DW-1:0] wdata_q;
   logic wr_pulse_q, rd_pulse_q;

   assign strobe_act = bus.bus_mode_select ? ~bus.slave_address_strobe : bus.slave_address_strobe;
   assign reg_live = (state_q == SAP_ACK) && !is_mem_q && !bus.chip_select_n && strobe_act;
   assign rdy_fire = reg_live && (rdy_cnt_q == 2'(`SAP_RDY_AFTER_ACK_CYC - 1)) && rdy_n_q;
   assign bus.slave_memory_ack_n = ack_n_q;
   assign bus.ready_out_n = rdy_n_q;
   assign bus.rdata = rdata_q;
   assign bus.rdata_oe = oe_q;
   assign reg_addr = addr_q;
   assign reg_wdata = wdata_q;
   assign reg_write = wr_pulse_q;
   assign reg_read = rd_pulse_q;
   assign mem_granted = mem_granted_q;

   ////////////////////////////////////////////////////////////////
   // Select synchroniser
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         cs_s1_q <= 1'b0;
         cs_s2_q <= 1'b0;
      end else begin
         cs_s1_q <= ~bus.chip_select_n;
         cs_s2_q <= cs_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Memory request synchroniser
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         mr_s1_q <= 1'b0;
         mr_s2_q <= 1'b0;
      end else begin
         mr_s1_q <= ~bus.shared_memory_request_n;
         mr_s2_q <= mr_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Access sequencer
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         state_q <= SAP_IDLE;
         dly_q <= 3'h0;
         is_mem_q <= 1'b0;
         ack_n_q <= 1'b1;
         mem_granted_q <= 1'b0;
      end else begin
         unique case (state_q)
            SAP_IDLE: begin
               ack_n_q <= 1'b1;
               if (mr_s2_q) begin
                  is_mem_q <= 1'b1;
                  state_q <= SAP_WAIT;
                  dly_q <= bus_master ? 3'(`SAP_ACK_MASTER_CYC - 1) : 3'(`SAP_ACK_IDLE_CYC - 1);
               end else if (cs_s2_q && strobe_act) begin
                  is_mem_q <= 1'b0;
                  state_q <= SAP_WAIT;
                  dly_q <= bus_master ? 3'(`SAP_ACK_MASTER_CYC - 1) : 3'(`SAP_ACK_IDLE_CYC - 1);
               end
            end
            SAP_WAIT: begin
               if (is_mem_q ? !mr_s2_q : !(cs_s2_q && strobe_act)) begin
                  state_q <= SAP_IDLE;
               end else if (bus_master && master_wait) begin
                  dly_q <= dly_q;
               end else if (dly_q == 3'h0) begin
                  ack_n_q <= 1'b0;
                  mem_granted_q <= is_mem_q;
                  state_q <= SAP_ACK;
               end else begin
                  dly_q <= dly_q - 3'h1;
               end
            end
            SAP_ACK: begin
               if (is_mem_q ? !mr_s2_q : !(~bus.chip_select_n && strobe_act)) begin
                  ack_n_q <= 1'b1;
                  mem_granted_q <= 1'b0;
                  state_q <= SAP_DONE;
               end
            end
            SAP_DONE: begin
               ack_n_q <= 1'b1;
               if (is_mem_q || !strobe_act || bus.chip_select_n) begin
                  state_q <= SAP_IDLE;
               end
            end
            default: state_q <= SAP_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // Ready output
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         rdy_cnt_q <= 2'h0;
         rdy_n_q <= 1'b1;
      end else if (!reg_live) begin
         rdy_cnt_q <= 2'h0;
         rdy_n_q <= 1'b1;
      end else if (rdy_cnt_q != 2'(`SAP_RDY_AFTER_ACK_CYC - 1)) begin
         rdy_cnt_q <= rdy_cnt_q + 2'h1;
      end else begin
         rdy_n_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Register strobes
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         wr_pulse_q <= 1'b0;
         rd_pulse_q <= 1'b0;
      end else begin
         wr_pulse_q <= rdy_fire & wr_q;
         rd_pulse_q <= rdy_fire & ~wr_q;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Read data drive
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         oe_q <= 1'b0;
         rdata_q <= '0;
      end else if (!reg_live) begin
         oe_q <= 1'b0;
      end else if (rdy_fire) begin
         oe_q <= ~wr_q;
         rdata_q <= reg_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Address and direction capture
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         addr_q <= '0;
         wr_q <= 1'b0;
      end else if (state_q == SAP_IDLE && strobe_act) begin
         addr_q <= bus.reg_addr;
         wr_q <= bus.slave_write_read;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Write data capture
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         wdata_q <= '0;
      end else if (state_q == SAP_ACK && wr_q) begin
         wdata_q <= bus.wdata;
      end
   end
endmodule : sap_device
`default_nettype wire

// *** hw/sap_host.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "sap_regs.svh"
module sap_host
   import sap_pkg::*;
#(
   parameter int AW = 6,
   parameter int DW = 16
) (
   input wire logic core_clk,
   input wire logic rstn,
   sap_if.host bus,
   input wire logic mode,
   input wire logic req_valid,
   input wire logic req_mem,
   input wire logic req_write,
   input wire logic [AW-1:0] req_addr,
   input wire logic [DW-1:0] req_wdata,
   input wire logic mem_release,
   output logic req_ready,
   output logic done,
   output logic [DW-1:0] rsp_rdata
);
   sap_host_state_type st_q;
   logic cs_q, mr_q, as_q, wr_q, mem_q, done_q, rdy_q, mode_q, rel_q;
   logic [AW-1:0] addr_q;
   logic [DW-1:0] wd_q, rd_q;
   logic [1:0] gap_q;

   assign bus.chip_select_n = ~cs_q;
   assign bus.shared_memory_request_n = ~mr_q;
   assign bus.slave_address_strobe = mode_q ? ~as_q : as_q;
   assign bus.slave_write_read = wr_q;
   assign bus.reg_addr = addr_q;
   assign bus.wdata = wd_q;
   assign bus.bus_mode_select = mode_q;
   assign req_ready = rdy_q;
   assign done = done_q;
   assign rsp_rdata = rd_q;

   ////////////////////////////////////////////////////////////////
   // Access driver
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st_q <= SAP_H_IDLE;
         cs_q <= 1'b0;
         mr_q <= 1'b0;
         as_q <= 1'b0;
         wr_q <= 1'b0;
         mem_q <= 1'b0;
         done_q <= 1'b0;
         rdy_q <= 1'b0;
         mode_q <= 1'b0;
         rel_q <= 1'b0;
         addr_q <= '0;
         wd_q <= '0;
         rd_q <= '0;
         gap_q <= 2'h0;
      end else begin
         done_q <= 1'b0;
         unique case (st_q)
            SAP_H_IDLE: begin
               if (gap_q != 2'h0) begin
                  gap_q <= gap_q - 2'h1;
                  rdy_q <= 1'b0;
               end else begin
                  rdy_q <= 1'b1;
               end
               if (req_valid && rdy_q) begin
                  rdy_q <= 1'b0;
                  mem_q <= req_mem;
                  mode_q <= mode;
                  wr_q <= req_write;
                  addr_q <= req_addr;
                  wd_q <= req_wdata;
                  mr_q <= req_mem;
                  cs_q <= ~req_mem;
                  as_q <= ~req_mem;
                  rel_q <= 1'b0;
                  st_q <= SAP_H_BUSY;
               end
            end
            SAP_H_BUSY: begin
               if (mem_q) begin
                  if (!bus.slave_memory_ack_n && mem_release) begin
                     mr_q <= 1'b0;
                     done_q <= 1'b1;
                     gap_q <= 2'(`SAP_SEL_GAP_CYC);
                     st_q <= SAP_H_IDLE;
                  end
               end else if (!rel_q && !bus.ready_out_n) begin
                  rd_q <= bus.rdata;
                  as_q <= 1'b0;
                  cs_q <= 1'b0;
                  rel_q <= 1'b1;
               end else if (rel_q) begin
                  done_q <= 1'b1;
                  gap_q <= 2'(`SAP_SEL_GAP_CYC);
                  st_q <= SAP_H_IDLE;
               end
            end
            default: st_q <= SAP_H_IDLE;
         endcase
      end
   end
endmodule : sap_host
`default_nettype wire

// *** hw/sap_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface sap_if #(parameter int AW = 6, parameter int DW = 16);
   logic chip_select_n;
   logic shared_memory_request_n;
   logic slave_address_strobe;
   logic slave_write_read;
   logic [AW-1:0] reg_addr;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;
   logic rdata_oe;
   logic slave_memory_ack_n;
   logic ready_out_n;
   logic bus_mode_select;
   modport device (
      input chip_select_n, shared_memory_request_n, slave_address_strobe, slave_write_read,
      input reg_addr, wdata, bus_mode_select,
      output rdata, rdata_oe, slave_memory_ack_n, ready_out_n
   );
   modport host (
      output chip_select_n, shared_memory_request_n, slave_address_strobe, slave_write_read,
      output reg_addr, wdata, bus_mode_select,
      input rdata, rdata_oe, slave_memory_ack_n, ready_out_n
   );
endinterface : sap_if
`default_nettype wire

// *** hw/sap_pkg.sv ***
package sap_pkg;
   typedef enum logic [3:0] {
      SAP_IDLE = 4'h1,
      SAP_WAIT = 4'h2,
      SAP_ACK = 4'h4,
      SAP_DONE = 4'h8
   } sap_state_type;
   typedef enum logic [1:0] {
      SAP_H_IDLE = 2'h1,
      SAP_H_BUSY = 2'h2
   } sap_host_state_type;
endpackage : sap_pkg

// *** hw/sap_regs.svh ***
`ifndef SAP_REGS_SVH
`define SAP_REGS_SVH
`define SAP_ACK_IDLE_CYC 1
`define SAP_ACK_MASTER_CYC 5
`define SAP_RDY_AFTER_ACK_CYC 3
`define SAP_SEL_GAP_CYC 2
`define SAP_CS_IDLE_CYC 1
`endif

// *** tb/sap_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module sap_props (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic chip_select_n,
   input wire logic shared_memory_request_n,
   input wire logic slave_address_strobe,
   input wire logic bus_mode_select,
   input wire logic rdata_oe,
   input wire logic slave_memory_ack_n,
   input wire logic ready_out_n
);
   logic cs;
   logic mq;
   logic ak;
   logic st;
   // Active-high views of the wire
   assign cs = !chip_select_n;
   assign mq = !shared_memory_request_n;
   assign ak = !slave_memory_ack_n;
   assign st = bus_mode_select ^ slave_address_strobe;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////
   AST_EXCL: assert property (!(cs && mq))
      else $error("select and request together");
   AST_GAP: assert property ($fell(cs) || $fell(mq) |-> (!cs && !mq) [*2])
      else $error("select gap too short");
   AST_LAT: assert property ($rose(cs || mq) |-> !ak [*2] ##[0:40] ak)
      else $error("ack timing");
   AST_MEMHOLD: assert property (ak && mq ##1 mq |-> ak)
      else $error("memory ack dropped");
   AST_REGACK: assert property ($rose(ak) && !mq |-> cs && st)
      else $error("register ack without strobe");
   AST_REL: assert property ($past(cs) && (!cs || !st) |=> !ak && ready_out_n && !rdata_oe)
      else $error("access not ended");
   AST_RDY: assert property ($fell(ready_out_n) && !bus_mode_select |-> $past(ak, 3) && $past(ak, 2) && ak)
      else $error("ready too early");
   AST_SASON: assert property ($rose(cs) |-> st)
      else $error("strobe late");
   AST_SASOFF: assert property ($fell(cs) |-> ##[0:1] !st)
      else $error("strobe held");
   cover property ($rose(ak) && mq);
   cover property ($fell(ready_out_n) && bus_mode_select);
   cover property ($fell(ready_out_n) && !bus_mode_select);
endmodule : sap_props
`default_nettype wire

// *** tb/slave_access_port_test.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "sap_regs.svh"
module slave_access_port_test;
   logic core_clk = 0, rstn = 0, mode = 0, req_valid = 0, req_mem = 0, req_write = 0;
   logic mem_release = 0, bus_master = 0, master_wait = 0;
   logic [5:0] req_addr = '0, reg_addr, cap_a;
   logic [15:0] req_wdata = '0, reg_rdata = '0, rsp_rdata, reg_wdata, cap_d;
   logic req_ready, done, reg_write, reg_read, mem_granted, ak_q;
   int n_errors = 0, tests_run = 0, cyc = 0, lat_q = 0, cnt_q = 0, seed = 32'he206;
   sap_if sap_bus ();
   sap_device u_sap_device (.core_clk(core_clk), .rstn(rstn), .bus(sap_bus), .bus_master(bus_master),
      .master_wait(master_wait), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_write(reg_write),
      .reg_wdata(reg_wdata), .reg_read(reg_read), .mem_granted(mem_granted));
   sap_host u_sap_host (.core_clk(core_clk), .rstn(rstn), .bus(sap_bus), .mode(mode), .req_valid(req_valid),
      .req_mem(req_mem), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .mem_release(mem_release), .req_ready(req_ready), .done(done), .rsp_rdata(rsp_rdata));
   sap_props u_sap_props (.core_clk(core_clk), .rstn(rstn), .chip_select_n(sap_bus.chip_select_n),
      .shared_memory_request_n(sap_bus.shared_memory_request_n), .rdata_oe(sap_bus.rdata_oe),
      .slave_address_strobe(sap_bus.slave_address_strobe), .bus_mode_select(sap_bus.bus_mode_select),
      .slave_memory_ack_n(sap_bus.slave_memory_ack_n), .ready_out_n(sap_bus.ready_out_n));
   ////////////////////////////////////////////////////////////////
   task check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check
   task conclude;
      if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude
   // Sync and entry cycles, ack delay, three held wait cycles
   function automatic int exp_lat(input logic m, input logic w);
      return 3 + (m ? `SAP_ACK_MASTER_CYC : `SAP_ACK_IDLE_CYC) + (w ? 3 : 0);
   endfunction : exp_lat
   // Ack latency and register port capture
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      ak_q <= sap_bus.slave_memory_ack_n;
      cnt_q <= sap_bus.chip_select_n ? 0 : cnt_q + 1;
      if (ak_q && !sap_bus.slave_memory_ack_n) lat_q <= cnt_q;
      if (reg_write || reg_read) cap_a <= reg_addr;
      if (reg_write) cap_d <= reg_wdata;
      if (cyc > 20000) begin
         n_errors++;
         conclude();
      end
   end
   task automatic op(input logic mem, input logic wr, input logic w);
      int k = 0;
      req_mem = mem;
      req_write = wr;
      req_addr = 6'($random(seed));
      req_wdata = 16'($random(seed));
      reg_rdata = 16'($random(seed));
      req_valid = 1;
      do @(posedge core_clk); while (!req_ready && ++k < 99);
      @(negedge core_clk);
      req_valid = 0;
      master_wait = w;
      repeat (6) @(negedge core_clk);
      master_wait = 0;
      if (!mem) begin
         while (!done && ++k < 99) @(negedge core_clk);
         check(done, 1);
         check(16'(cap_a), 16'(req_addr));
         check(wr ? cap_d : rsp_rdata, wr ? req_wdata : reg_rdata);
         check(16'(lat_q), 16'(exp_lat(bus_master, w)));
      end else begin
         while (sap_bus.slave_memory_ack_n && ++k < 99) @(negedge core_clk);
         check(mem_granted, 1);
         repeat (2 + {$random(seed)} % 6) @(negedge core_clk);
         check(sap_bus.slave_memory_ack_n, 0);
         mem_release = 1;
         @(negedge core_clk);
         mem_release = 0;
         check(done, 1);
         k = 0;
         while (!sap_bus.slave_memory_ack_n && ++k < 20) @(negedge core_clk);
         check(sap_bus.slave_memory_ack_n, 1);
      end
      repeat (3) @(negedge core_clk);
   endtask : op
   ////////////////////////////////////////////////////////////////
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   initial begin
      repeat (10) @(negedge core_clk);
      rstn = 1;
      @(negedge core_clk);
      for (int i = 0; i < 24; i++) begin
         mode = i[0];
         bus_master = i > 3 && i[1];
         op(0, i[2], i > 16 && i[1]);
      end
      for (int i = 0; i < 4; i++) op(1, 0, 0);
      conclude();
   end
endmodule : slave_access_port_test
`default_nettype wire
